// ### include/dsc_pkg.sv
/*
 * Constants, types and timing counts for the deep sleep controller.
 * Assumes a single 40 MHz core clock and select and reset pins that idle high when the host is quiet.
 */
package dsc_pkg;

    // Mode configuration register layout, most significant field first
    typedef struct packed {
        logic       sleep_en;
        logic [2:0] drive;
        logic [3:0] rsvd;
        logic [3:0] lat_code;
        logic       lat_fixed;
        logic       burst_hybrid;
        logic [1:0] burst_len;
    } dsc_mode_t;

    // Sampled link pins, all idle high except the clock
    typedef struct packed {
        logic cs_n;
        logic reset_n;
        logic link_clk;
    } dsc_pins_t;

    localparam int SYNC_W = 3;
    localparam logic [SYNC_W-1:0] PINS_IDLE = 3'h6;

    // Reset value: normal operation, strongest drive, latency 8, variable, wrapped, 32 bytes
    localparam logic [15:0] MODE_RESET = 16'hF052;
    // Reserved bits 11..8 are not writable
    localparam logic [15:0] MODE_WR_MASK = 16'hF0FF;
    localparam int SLEEP_EN_BIT = 15;

    // Times as printed, in microseconds
    localparam int MIN_SLEEP_HOLD_TIME_US = 500;
    localparam int WAKE_TO_CLOCK_SETUP_TIME_US = 150;
    localparam int RESET_WAKE_TO_COMMAND_TIME_US = 150;
    localparam int SLEEP_REENTRY_GAP_US = 500;

    // Core clock period and derived cycle counts, least times rounded up
    localparam int MCLK_PERIOD_NS = 25;
    localparam int MIN_SLEEP_HOLD_CYC = (MIN_SLEEP_HOLD_TIME_US * 1000 + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam int WAKE_SETUP_CYC = (WAKE_TO_CLOCK_SETUP_TIME_US * 1000 + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam int RESET_WAKE_CYC = (RESET_WAKE_TO_COMMAND_TIME_US * 1000 + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam int REENTRY_GAP_CYC = (SLEEP_REENTRY_GAP_US * 1000 + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

    // Counter width holds the largest count, 20000 cycles
    localparam int CNT_W = 15;

endpackage

// ### hw/dsc_sync.sv
/*
 * Two-flop synchroniser for the link pins.
 * Assumes the pins are asynchronous to i_mclk; first stage is read only by the second.
 */
module dsc_sync
#(
    parameter int W = 3,
    parameter logic [W-1:0] IDLE = '0
)
(
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // Pins in, synchronised copy out
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);

    genvar g;

    // One two-stage chain per pin; reset loads the idle level so no false edge appears
    generate
        for (g = 0; g < W; g++)
        begin : g_bit
            logic meta;
            logic stable;
            always_ff @(posedge i_mclk or posedge i_rst)
            begin
                if (i_rst)
                begin
                    meta <= IDLE[g];
                    stable <= IDLE[g];
                end
                else
                begin
                    meta <= i_async[g];
                    stable <= meta;
                end
            end
            assign o_sync[g] = stable;
        end
    endgenerate

endmodule

// ### hw/dsc_ctrl.sv
/*
 * Deep sleep entry and exit control with the mode configuration register it guards.
 * Assumes config writes arrive as one-cycle pulses from command logic on i_mclk,
 * and that chip select, reset and link clock are raw pins from the host.
 */
module dsc_ctrl
#(
    parameter int SLEEP_HOLD_CYC = dsc_pkg::MIN_SLEEP_HOLD_CYC,
    parameter int WAKE_CYC = dsc_pkg::WAKE_SETUP_CYC,
    parameter int RST_WAKE_CYC = dsc_pkg::RESET_WAKE_CYC,
    parameter int GAP_CYC = dsc_pkg::REENTRY_GAP_CYC
)
(
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // Link pins from the host
    input wire dsc_pkg::dsc_pins_t i_pins,
    // Config write from command logic
    input wire logic i_cfg_wr,
    input wire dsc_pkg::dsc_mode_t i_cfg_data,
    // Flag clears from command logic
    input wire logic i_lost_clr,
    input wire logic i_err_clr,
    // Status
    output dsc_pkg::dsc_mode_t o_mode,
    output logic o_sleep,
    output logic o_ready,
    output logic o_array_lost,
    output logic o_gap_busy,
    output logic o_proto_err
);
    import dsc_pkg::*;

    typedef enum logic [2:0] {
        ST_AWAKE,
        ST_ARMED,
        ST_SLEEP,
        ST_LOWPULSE,
        ST_SETTLE,
        ST_RST_HOLD
    } dsc_state_t;

    dsc_pins_t pins_s;
    logic lclk_d;
    logic lclk_rise;
    logic cs_hi;
    logic rst_rel;

    dsc_state_t state;
    dsc_state_t next_state;
    dsc_mode_t mode;
    dsc_mode_t next_mode;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic [CNT_W-1:0] gap;
    logic [CNT_W-1:0] next_gap;
    logic lost;
    logic next_lost;
    logic err;
    logic next_err;
    logic set_lost;
    logic set_err;

    // True in the states where the core is powered down
    function automatic logic in_sleep(input dsc_state_t s);
        in_sleep = (s == ST_SLEEP) || (s == ST_LOWPULSE);
    endfunction

    // Pins cross into the core clock here
    dsc_sync #(
        .W(SYNC_W),
        .IDLE(PINS_IDLE)
    ) u_sync (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_async(i_pins),
        .o_sync(pins_s)
    );

    assign cs_hi = pins_s.cs_n;
    assign rst_rel = pins_s.reset_n;
    // The host clock stands still outside frames, so only its rising edge is looked at
    assign lclk_rise = pins_s.link_clk & ~lclk_d;

    // Edge detector stage behind the synchroniser
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
            lclk_d <= 1'b0;
        else
            lclk_d <= pins_s.link_clk;
    end

    // Sequencer next state, mode register and counters
    always_comb
    begin
        next_state = state;
        next_mode = mode;
        next_cnt = (cnt != '0) ? cnt - 1'b1 : cnt;
        next_gap = (gap != '0) ? gap - 1'b1 : gap;
        set_lost = 1'b0;
        set_err = 1'b0;
        if (!rst_rel)
        begin
            // Reset pin low wins over everything and restores defaults
            next_state = ST_RST_HOLD;
            next_mode = dsc_mode_t'(MODE_RESET);
            next_cnt = CNT_W'(RST_WAKE_CYC);
        end
        else
        begin
            unique case (state)
                ST_AWAKE:
                begin
                    if (i_cfg_wr)
                    begin
                        next_mode = dsc_mode_t'(16'(i_cfg_data) & MODE_WR_MASK);
                        if (!i_cfg_data.sleep_en)
                        begin
                            next_state = ST_ARMED;
                            set_err = (gap != '0);
                        end
                    end
                end
                ST_ARMED:
                begin
                    if (i_cfg_wr)
                    begin
                        // A later write may cancel the pending entry
                        next_mode = dsc_mode_t'(16'(i_cfg_data) & MODE_WR_MASK);
                        if (i_cfg_data.sleep_en)
                            next_state = ST_AWAKE;
                    end
                    else if (cs_hi)
                    begin
                        next_state = ST_SLEEP;
                        next_cnt = CNT_W'(SLEEP_HOLD_CYC);
                        set_lost = 1'b1;
                    end
                end
                ST_SLEEP:
                begin
                    // Writes are ignored here, so the mode register is retained
                    if (!cs_hi)
                    begin
                        next_state = ST_LOWPULSE;
                        set_err = (cnt != '0);
                    end
                end
                ST_LOWPULSE:
                begin
                    if (cs_hi)
                    begin
                        next_state = ST_SETTLE;
                        next_mode.sleep_en = 1'b1;
                        next_cnt = CNT_W'(WAKE_CYC);
                    end
                end
                ST_SETTLE:
                begin
                    // Select low or host clocking before the wait is over is flagged
                    set_err = !cs_hi || lclk_rise;
                    if (cnt == '0)
                    begin
                        next_state = ST_AWAKE;
                        next_gap = CNT_W'(GAP_CYC);
                    end
                end
                ST_RST_HOLD:
                begin
                    next_state = ST_SETTLE;
                end
            endcase
        end
        // Setting wins over a clear in the same cycle
        next_lost = set_lost | (lost & ~i_lost_clr);
        next_err = set_err | (err & ~i_err_clr);
    end

    // Registers; the gap counter starts loaded so power-up counts as an exit
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state <= ST_AWAKE;
            mode <= dsc_mode_t'(MODE_RESET);
            cnt <= '0;
            gap <= CNT_W'(GAP_CYC);
            lost <= 1'b0;
            err <= 1'b0;
        end
        else
        begin
            state <= next_state;
            mode <= next_mode;
            cnt <= next_cnt;
            gap <= next_gap;
            lost <= next_lost;
            err <= next_err;
        end
    end

    // Status outputs, decoded from registered state
    assign o_mode = mode;
    assign o_sleep = in_sleep(state);
    assign o_ready = (state == ST_AWAKE) || (state == ST_ARMED);
    assign o_array_lost = lost;
    assign o_gap_busy = (gap != '0);
    assign o_proto_err = err;

    // Checks on the sequencer
    sequence s_low_pulse;
        (state == ST_LOWPULSE) && !cs_hi && rst_rel ##1 (state == ST_LOWPULSE);
    endsequence

    property p_entry_arm;
        @(posedge i_mclk) disable iff (i_rst)
        (state == ST_AWAKE) && rst_rel && i_cfg_wr && !i_cfg_data.sleep_en |=> (state == ST_ARMED) && !o_mode.sleep_en;
    endproperty
    a_entry_arm: assert property (p_entry_arm) else $error("entry write did not arm sleep");

    property p_sleep_start;
        @(posedge i_mclk) disable iff (i_rst)
        (state == ST_ARMED) && rst_rel && cs_hi && !i_cfg_wr |=> o_sleep && !o_ready;
    endproperty
    a_sleep_start: assert property (p_sleep_start) else $error("select high did not start sleep");

    property p_wake_pulse;
        @(posedge i_mclk) disable iff (i_rst)
        s_low_pulse ##0 (cs_hi && rst_rel) |=> !o_sleep && (state == ST_SETTLE) && o_mode.sleep_en;
    endproperty
    a_wake_pulse: assert property (p_wake_pulse) else $error("select pulse did not wake");

    property p_keep_cfg;
        @(posedge i_mclk) disable iff (i_rst)
        o_sleep ##1 o_sleep |-> $stable(o_mode);
    endproperty
    a_keep_cfg: assert property (p_keep_cfg) else $error("config changed during sleep");

    property p_array_lost;
        @(posedge i_mclk) disable iff (i_rst)
        $rose(o_sleep) |-> o_array_lost;
    endproperty
    a_array_lost: assert property (p_array_lost) else $error("array loss not flagged");

    property p_reset_default;
        @(posedge i_mclk) disable iff (i_rst)
        o_sleep && !rst_rel |=> (16'(o_mode) == MODE_RESET) && !o_sleep ##1 (state == ST_RST_HOLD || state == ST_SETTLE);
    endproperty
    a_reset_default: assert property (p_reset_default) else $error("reset pin wake kept config");

    property p_default_one;
        @(posedge i_mclk) disable iff (i_rst)
        (state == ST_SETTLE) || (state == ST_RST_HOLD) |-> o_mode.sleep_en && !o_ready;
    endproperty
    a_default_one: assert property (p_default_one) else $error("sleep enable not normal after wake");

endmodule

// ### verification/dsc_host.sv
/*
 * Host controller model: drives chip select, reset pin and link clock toward the sleep controller.
 * Assumes the bench calls its tasks from one process; pins idle high, link clock still outside frames except in the stray_clk misuse.
 */
module dsc_host
#(
    parameter int HOLD = 20,
    parameter int WAKE = 10,
    parameter int GAP = 30
)
(
    // Core clock used only for pacing
    input wire logic i_mclk,
    // Pins toward the device
    output dsc_pkg::dsc_pins_t o_pins
);
    timeunit 1ns;
    timeprecision 1ps;
    import dsc_pkg::*;

    // Quiet host: select and reset high, clock stopped
    initial o_pins = '{cs_n: 1'b1, reset_n: 1'b1, link_clk: 1'b0};

    // Every pin change except the link clock inside a frame lands a little after a core clock edge
    task automatic idle(input int n);
        repeat (n) @(posedge i_mclk);
        #2;
    endtask

    // Select stays high for the least sleep time before any wake
    task automatic hold_sleep();
        idle(HOLD + 4);
    endtask

    // Spacing before the next entry request, margin covers synchroniser delay
    task automatic gap_wait();
        idle(GAP + 4);
    endtask

    // Low pulse on select wakes the device
    task automatic cs_pulse(input int low);
        idle(1);
        o_pins.cs_n = 1'b0;
        idle(low);
        o_pins.cs_n = 1'b1;
    endtask

    // Wake by select pulse; no operation until setup has run out
    task automatic cs_wake(input int low);
        cs_pulse(low);
        idle(WAKE + 8);
    endtask

    // Deliberate misuse: one host clock edge while the device still settles
    task automatic stray_clk();
        idle(2);
        o_pins.link_clk = 1'b1;
        #100;
        o_pins.link_clk = 1'b0;
        #100;
        idle(1);
    endtask

    // Wake through the reset pin; select and reset stay high while the device settles
    task automatic rst_wake();
        idle(1);
        o_pins.reset_n = 1'b0;
        idle(4);
        o_pins.reset_n = 1'b1;
        idle(WAKE + 8);
    endtask

    // One operation frame; the 200 ns link clock is off phase with the core clock
    task automatic frame();
        idle(1);
        o_pins.cs_n = 1'b0;
        #13;
        repeat (4)
        begin
            o_pins.link_clk = 1'b1;
            #100;
            o_pins.link_clk = 1'b0;
            #100;
        end
        idle(1);
        o_pins.cs_n = 1'b1;
    endtask
endmodule

// ### verification/tb.sv
/*
 * Self-checking bench for the deep sleep controller with short timing parameters.
 * Assumes the host model owns the pins; the bench owns config writes and flag clears.
 */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dsc_pkg::*;

    localparam int HOLD = 20;
    localparam int WAKE = 10;
    localparam int GAP = 30;

    logic i_mclk = 1'b0;
    logic i_rst = 1'b1;
    logic i_cfg_wr = 1'b0;
    logic i_lost_clr = 1'b0;
    logic i_err_clr = 1'b0;
    dsc_mode_t i_cfg_data = '0;
    dsc_pins_t pins;
    dsc_mode_t o_mode;
    logic o_sleep, o_ready, o_array_lost, o_gap_busy, o_proto_err;
    logic [31:0] seed = 32'd68146;
    int num_errors = 0;
    int n_tests = 0;
    dsc_mode_t d, k;

    // Short counts keep the run brief; expectations use the same values
    dsc_ctrl #(.SLEEP_HOLD_CYC(HOLD), .WAKE_CYC(WAKE), .RST_WAKE_CYC(WAKE), .GAP_CYC(GAP)) i_dut (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_pins(pins), .i_cfg_wr(i_cfg_wr), .i_cfg_data(i_cfg_data),
        .i_lost_clr(i_lost_clr), .i_err_clr(i_err_clr), .o_mode(o_mode), .o_sleep(o_sleep),
        .o_ready(o_ready), .o_array_lost(o_array_lost), .o_gap_busy(o_gap_busy), .o_proto_err(o_proto_err));
    dsc_host #(.HOLD(HOLD), .WAKE(WAKE), .GAP(GAP)) u_host (.i_mclk(i_mclk), .o_pins(pins));

    // 40 MHz core clock
    initial
    begin
        forever #12.5 i_mclk = ~i_mclk;
    end

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
        begin
            $display("verification passed");
        end
        else
        begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Register contents as the rules predict: reserved bits drop, a wake restores normal mode
    function automatic logic [15:0] exp_mode(input logic [15:0] w, input logic woke);
        return (w & MODE_WR_MASK) | (woke ? 16'h8000 : 16'h0000);
    endfunction

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic nxt(input logic en, output dsc_mode_t v);
        seed = xs(seed);
        v = seed[15:0];
        v.sleep_en = en;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge i_mclk);
        #2;
    endtask

    // One write pulse, then one more edge so the register has settled
    task automatic wr(input dsc_mode_t v);
        i_cfg_data = v;
        i_cfg_wr = 1'b1;
        step(1);
        i_cfg_wr = 1'b0;
        step(1);
    endtask

    // Bounded wait for the sleep flag to reach a level
    task automatic wait_sleep(input logic v);
        int n = 0;
        while (o_sleep !== v && n < 100)
        begin
            step(1);
            n++;
        end
        if (o_sleep !== v)
        begin
            num_errors++;
            $display("[FAIL] %0t sleep flag wait timed out", $time);
            wrap_up();
        end
    endtask

    task automatic clr(input logic lost, input logic err);
        i_lost_clr = lost;
        i_err_clr = err;
        step(1);
        i_lost_clr = 1'b0;
        i_err_clr = 1'b0;
        step(1);
    endtask

    initial
    begin
        step(2);
        i_rst = 1'b0;
        chk(o_mode, MODE_RESET);
        chk({11'h0, o_sleep, o_ready, o_gap_busy, o_array_lost, o_proto_err}, 16'h000C);
        // Random writes in normal mode, reserved bits never stick
        repeat (6)
        begin
            nxt(1'b1, d);
            wr(d);
            chk(o_mode, exp_mode(d, 1'b0));
        end
        u_host.gap_wait();
        chk({15'h0, o_gap_busy}, 16'h0000);
        // Entry, refused write in sleep, proper hold then select pulse wake
        nxt(1'b0, d);
        wr(d);
        chk(o_mode, exp_mode(d, 1'b0));
        wait_sleep(1'b1);
        chk({14'h0, o_array_lost, o_ready}, 16'h0002);
        nxt(1'b1, k);
        wr(k);
        chk(o_mode, exp_mode(d, 1'b0));
        u_host.hold_sleep();
        u_host.cs_wake(3);
        chk(o_mode, exp_mode(d, 1'b1));
        chk({12'h0, o_sleep, o_ready, o_array_lost, o_proto_err}, 16'h0006);
        chk({15'h0, o_gap_busy}, 16'h0001);
        // An operation frame once the wake setup is over raises no flag
        u_host.frame();
        chk({15'h0, o_proto_err}, 16'h0000);
        clr(1'b1, 1'b0);
        chk({15'h0, o_array_lost}, 16'h0000);
        // Early wake is still taken but flagged
        u_host.gap_wait();
        nxt(1'b0, d);
        wr(d);
        wait_sleep(1'b1);
        u_host.cs_wake(3);
        chk({14'h0, o_ready, o_proto_err}, 16'h0003);
        clr(1'b0, 1'b1);
        chk({15'h0, o_proto_err}, 16'h0000);
        // Entry inside the gap is flagged, then the reset pin wake restores defaults
        nxt(1'b0, d);
        wr(d);
        chk({15'h0, o_proto_err}, 16'h0001);
        wait_sleep(1'b1);
        u_host.hold_sleep();
        u_host.rst_wake();
        chk(o_mode, MODE_RESET);
        chk({14'h0, o_sleep, o_ready}, 16'h0001);
        // Host clocking before the wake setup has run out is flagged
        clr(1'b0, 1'b1);
        chk({15'h0, o_proto_err}, 16'h0000);
        u_host.gap_wait();
        nxt(1'b0, d);
        wr(d);
        wait_sleep(1'b1);
        u_host.hold_sleep();
        u_host.cs_pulse(3);
        u_host.stray_clk();
        u_host.idle(WAKE + 8);
        chk({14'h0, o_ready, o_proto_err}, 16'h0003);
        wrap_up();
    end
endmodule
